/* hw/arbiter_cfg.svh */
// Register offsets, field positions, reset values and counts of the arbiter
`ifndef ARBITER_CFG_SVH
`define ARBITER_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define ARB_PARK_CONTROL_OFFSET 8'h00
`define ARB_PARK_CONTROL_RESET  32'h00E10000
// Bits that software may change; all others read as zero
`define ARB_PARK_CONTROL_WMASK  32'h03FF7F00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ARB_DMA_BOOST_BIT       25
`define ARB_DMA_WIDE_BIT        24
`define ARB_M3_PRIO_LSB         22
`define ARB_M2_PRIO_LSB         20
`define ARB_M0_PRIO_LSB         18
`define ARB_M1_PRIO_LSB         16
`define ARB_FIXED_BIT           14
`define ARB_LOCKOUT_EN_BIT      13
`define ARB_PARK_TOP_BIT        12
`define ARB_LOCKOUT_EXP_LSB     8

// ----------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------
`define ARB_LOCK_CNT_W          17
`define ARB_DMA_BOOST_SCORE     3'h4

`endif

/* hw/arbiter_pkg.sv */
// Types shared by the bus arbiter
package arbiter_pkg;

    // ------------------------------------------------------------------
    // Arbitration algorithm
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        ARB_ROUND_ROBIN = 1'b0,
        ARB_FIXED       = 1'b1
    } arb_mode_t;

    // ------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] rsvd_hi;
        logic       dma_priority_boost_enable;
        logic       dma_wide_byte_count_select;
        logic [1:0] master3_priority;
        logic [1:0] master2_priority;
        logic [1:0] master0_priority;
        logic [1:0] master1_priority;
        logic       rsvd_mid;
        arb_mode_t  fixed_mode;
        logic       lockout_enable;
        logic       park_on_top_priority;
        logic [3:0] lockout_exponent;
        logic [7:0] rsvd_lo;
    } park_ctrl_t;

    // ------------------------------------------------------------------
    // AXI4-Lite response codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_DECERR = 2'b11
    } axi_resp_t;

endpackage

/* hw/four_master_bus_arbiter.sv */
// Four-port pipelined bus arbiter with AXI4-Lite control register
`timescale 1ns/1ns
`include "arbiter_cfg.svh"

// What this block does
// - Pointed master gets bus immediately; others wait
// - Granted master excluded; rest pick next pointer
// - Fixed mode: highest programmed priority requester wins
// - Fixed mode: owner holds bus while it keeps requesting
// - Round robin: priority offset by current master
// - Round robin arbitration after reset
// - Finished master drops lowest, others rotate
// - Idle pointer parks on top or last
// - Lock-out fields ignored in round robin
// - Per-master counters count denied request cycles
// - Counter at limit forces temporary round robin
// - Lock-out limit is two to exponent
// - Bit 14 selects fixed or round robin
// - Two-bit priority field per master
// - Initial order: 3, 2, 1, 0
// - Duplicate priorities fall back to initial order
// - Bit 25 enables DMA priority elevation
// - Bit 24 drives DMA byte count width
// - Exactly four masters, numbered 0 to 3
module four_master_bus_arbiter #(
    parameter int ADDR_W  = 8,
    parameter int MASTERS = 4
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 nrst,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Masters
    input  wire logic [MASTERS-1:0]   master_req,
    input  wire logic                 addr_phase_avail,
    input  wire logic                 xfer_done,
    input  wire logic                 dma_bw_request,
    output logic [MASTERS-1:0]        master_grant,
    output logic [1:0]                arb_pointer,
    output logic [1:0]                bus_owner,
    // DMA configuration
    output logic                      dma_wide_byte_count_select
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (MASTERS != 4)
    begin : g_bad_masters
        $error("arbiter serves exactly four master ports");
    end
    if (ADDR_W < 3)
    begin : g_bad_addr
        $error("address must reach at least one word");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    arbiter_pkg::park_ctrl_t      ctrl_reg;
    logic [1:0]                   ptr_reg;
    logic [1:0]                   owner_reg;
    logic [1:0]                   offset_reg;
    logic [`ARB_LOCK_CNT_W-1:0]   lock_cnt_reg [MASTERS];
    logic [`ARB_LOCK_CNT_W-1:0]   lock_limit;
    logic [ADDR_W-1:0]            awaddr_reg;
    logic [31:0]                  wdata_reg;
    logic [3:0]                   wstrb_reg;
    logic                         aw_have_reg;
    logic                         w_have_reg;
    logic [1:0]                   prio [MASTERS];
    logic [1:0]                   prog [MASTERS];
    logic [2:0]                   score [MASTERS];
    logic                         dup;
    logic                         lock_any;
    logic                         rr_active;
    logic                         hold_owner;
    logic [MASTERS-1:0]           cand;
    logic [1:0]                   win_idx;
    logic [1:0]                   top_idx;
    logic [1:0]                   cur_idx;
    logic [1:0]                   ptr_next;
    logic [31:0]                  wr_merge;
    logic                         wr_fire;

    // ------------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------------
    always_comb
    begin
        prog[0] = ctrl_reg.master0_priority;
        prog[1] = ctrl_reg.master1_priority;
        prog[2] = ctrl_reg.master2_priority;
        prog[3] = ctrl_reg.master3_priority;
        dup = 1'b0;
        for (int i = 0; i < MASTERS; i++)
            for (int j = i + 1; j < MASTERS; j++)
                if (prog[i] == prog[j])
                    dup = 1'b1;
        // Initial order gives each master its own index
        for (int i = 0; i < MASTERS; i++)
            prio[i] = dup ? 2'(i) : prog[i];
    end

    // Any counter at its limit forces round robin until all clear
    assign lock_limit = `ARB_LOCK_CNT_W'(1) << ctrl_reg.lockout_exponent;
    always_comb
    begin
        lock_any = 1'b0;
        for (int i = 0; i < MASTERS; i++)
            if (lock_cnt_reg[i] >= lock_limit)
                lock_any = 1'b1;
    end

    assign rr_active = (ctrl_reg.fixed_mode == arbiter_pkg::ARB_ROUND_ROBIN)
                       || lock_any;

    always_comb
    begin
        for (int i = 0; i < MASTERS; i++)
            if (rr_active)
                score[i] = {1'b0, 2'(prio[i] + offset_reg)};
            else
                score[i] = {1'b0, prio[i]};
        if (ctrl_reg.dma_priority_boost_enable && dma_bw_request)
            score[2] = `ARB_DMA_BOOST_SCORE;
    end

    // ------------------------------------------------------------------
    // Grant and next pointer
    // ------------------------------------------------------------------
    always_comb
    begin
        master_grant = '0;
        if (addr_phase_avail && master_req[ptr_reg])
            master_grant[ptr_reg] = 1'b1;
    end

    // Master granted now, else the last one; owner_reg lags a grant by
    // one cycle, so holding or parking on it alone would bounce the bus
    assign cur_idx    = |master_grant ? ptr_reg : owner_reg;
    assign cand       = master_req & ~master_grant;
    assign hold_owner = !rr_active && master_req[cur_idx];

    always_comb
    begin
        win_idx = 2'h0;
        top_idx = 2'h0;
        for (int i = 1; i < MASTERS; i++)
        begin
            if (cand[i] && (!cand[win_idx] || score[i] > score[win_idx]))
                win_idx = 2'(i);
            if (score[i] > score[top_idx])
                top_idx = 2'(i);
        end
    end

    always_comb
        if (hold_owner)
            ptr_next = cur_idx;
        else if (|cand)
            ptr_next = win_idx;
        else if (ctrl_reg.park_on_top_priority)
            ptr_next = top_idx;
        else
            ptr_next = cur_idx;

    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            ptr_reg <= 2'h0;
        else
            ptr_reg <= ptr_next;

    // Last granted master, also the park target when idle unless parking on top
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            owner_reg <= 2'h0;
        else
            for (int i = 0; i < MASTERS; i++)
                if (master_grant[i])
                    owner_reg <= 2'(i);

    // Finished master falls to lowest, the others rotate in their cyclic order behind it
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            offset_reg <= 2'h0;
        else if (rr_active && xfer_done)
            offset_reg <= 2'(2'h0 - prio[owner_reg]);

    // ------------------------------------------------------------------
    // Lock-out counters
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            for (int i = 0; i < MASTERS; i++)
                lock_cnt_reg[i] <= '0;
        else
            for (int i = 0; i < MASTERS; i++)
                if (ctrl_reg.fixed_mode == arbiter_pkg::ARB_ROUND_ROBIN
                    || !ctrl_reg.lockout_enable || !master_req[i]
                    || master_grant[i])
                    lock_cnt_reg[i] <= '0;
                else if (lock_cnt_reg[i] < lock_limit)
                    lock_cnt_reg[i] <= lock_cnt_reg[i] + 1'b1;

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
    assign wr_fire       = aw_have_reg && w_have_reg && !s_axi_bvalid;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            awaddr_reg  <= '0;
            wdata_reg   <= 32'h00000000;
            wstrb_reg   <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            else if (wr_fire)
            begin
                aw_have_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            else if (wr_fire)
            begin
                w_have_reg <= 1'b0;
            end
        end
    end

    always_comb
        for (int b = 0; b < 4; b++)
            wr_merge[b*8 +: 8] = wstrb_reg[b] ? wdata_reg[b*8 +: 8]
                                              : ctrl_reg[b*8 +: 8];

    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            ctrl_reg <= `ARB_PARK_CONTROL_RESET;
        else if (wr_fire && awaddr_reg[ADDR_W-1:2]
                 == (ADDR_W-2)'(`ARB_PARK_CONTROL_OFFSET >> 2))
            ctrl_reg <= wr_merge & `ARB_PARK_CONTROL_WMASK;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= arbiter_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            if (awaddr_reg[ADDR_W-1:2]
                == (ADDR_W-2)'(`ARB_PARK_CONTROL_OFFSET >> 2))
            begin
                s_axi_bresp <= arbiter_pkg::RESP_OKAY;
            end
            else
            begin
                s_axi_bresp <= arbiter_pkg::RESP_DECERR;
            end
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= arbiter_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[ADDR_W-1:2]
                == (ADDR_W-2)'(`ARB_PARK_CONTROL_OFFSET >> 2))
            begin
                s_axi_rdata <= ctrl_reg;
                s_axi_rresp <= arbiter_pkg::RESP_OKAY;
            end
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= arbiter_pkg::RESP_DECERR;
            end
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign arb_pointer = ptr_reg;
    assign bus_owner   = owner_reg;
    assign dma_wide_byte_count_select =
        ctrl_reg.dma_wide_byte_count_select;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_grant_pointer: assert property (@(posedge mclk) disable iff (!nrst)
        master_grant != '0 |-> master_grant[ptr_reg] && master_req[ptr_reg]
        && addr_phase_avail)
        else $error("grant not at pointed requesting master");

    chk_grant_onehot: assert property (@(posedge mclk) disable iff (!nrst)
        $onehot0(master_grant))
        else $error("more than one master granted");

    chk_park_top: assert property (@(posedge mclk) disable iff (!nrst)
        master_req == '0 && !hold_owner && ctrl_reg.park_on_top_priority
        |=> ptr_reg == $past(top_idx))
        else $error("idle pointer not parked on top master");

    chk_park_last: assert property (@(posedge mclk) disable iff (!nrst)
        master_req == '0 && !ctrl_reg.park_on_top_priority
        |=> ptr_reg == $past(owner_reg))
        else $error("idle pointer not parked on last master");

    chk_fixed_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !rr_active && master_req[owner_reg] ##1 master_req[owner_reg]
        && !rr_active |-> ptr_reg == owner_reg)
        else $error("fixed mode owner lost the bus early");

    chk_lock_limit: assert property (@(posedge mclk) disable iff (!nrst)
        ctrl_reg.fixed_mode == arbiter_pkg::ARB_ROUND_ROBIN
        |=> !lock_any)
        else $error("lock-out active in round robin mode");

    chk_rr_rotate: assert property (@(posedge mclk) disable iff (!nrst)
        rr_active && xfer_done |=> 2'(prio[$past(owner_reg)] + offset_reg)
        == 2'h0)
        else $error("finished master not moved to lowest priority");

    chk_dup_default: assert property (@(posedge mclk) disable iff (!nrst)
        dup |-> prio[3] == 2'h3 && prio[0] == 2'h0)
        else $error("duplicate priorities not replaced by defaults");

    chk_lock_enter: assert property (@(posedge mclk) disable iff (!nrst)
        lock_cnt_reg[0] == lock_limit - 1'b1 && master_req[0]
        && !master_grant[0] && !rr_active && ctrl_reg.lockout_enable
        ##1 $stable(ctrl_reg) |-> rr_active)
        else $error("counter at limit did not force round robin");

endmodule // four_master_bus_arbiter

/* bench/bus_masters_model.sv */
// Behavioural model of the four bus masters facing the arbiter
`timescale 1ns/1ns
module bus_masters_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // Bench wishes and arbiter answer
    input  wire logic [3:0] want,
    input  wire logic [3:0] grant,
    // Requests and completion towards the arbiter
    output logic [3:0]      master_req,
    output logic            xfer_done
);
    // ------------------------------------------------------------------
    // Masters
    // ------------------------------------------------------------------
    // Requests move only just after an edge, as real masters do
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            master_req <= 4'h0;
        else
            master_req <= want;

    // Each granted address phase finishes one cycle later
    always_ff @(posedge mclk or negedge nrst)
        if (!nrst)
            xfer_done <= 1'b0;
        else
            xfer_done <= |grant;
endmodule // bus_masters_model

/* bench/four_master_bus_arbiter_bench.sv */
// Self-checking bench for the four-port bus arbiter
`timescale 1ns/1ns
`include "arbiter_cfg.svh"
module four_master_bus_arbiter_bench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        avail, done, bw, wide;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, want, req, grant;
    logic [1:0]  bresp, rresp, ptr, owner;
    int          miscompares, n_tests, gcnt[4];
    logic [31:0] tc[5] = '{32'h00E14000, 32'h02E14000, 32'h00E14000,
                           32'h002D4000, 32'h000D4000};
    logic [3:0]  tw[5] = '{4'hC, 4'hC, 4'hC, 4'hC, 4'hA};
    logic        tb[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    logic [3:0]  te[5] = '{4'h3, 4'h2, 4'h3, 4'h2, 4'h3};

    four_master_bus_arbiter dut (
        .mclk(mclk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .master_req(req), .addr_phase_avail(avail), .xfer_done(done),
        .dma_bw_request(bw), .master_grant(grant), .arb_pointer(ptr),
        .bus_owner(owner), .dma_wide_byte_count_select(wide)
    );

    bus_masters_model masters (
        .mclk(mclk), .nrst(nrst), .want(want), .grant(grant),
        .master_req(req), .xfer_done(done)
    );

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------
    task automatic test_done;
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp_word(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic cmp_small(input string nm, input logic [3:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic expire;
        miscompares++;
        $display("MISMATCH bus_wait exp answer got none");
        test_done();
    endtask

    // ------------------------------------------------------------------
    // Register bus master
    // ------------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        bready <= 1'b0;
        r = bresp;
        if (n == 40)
            expire();
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        if (n == 40)
            expire();
    endtask

    task automatic set_ctrl(input logic [31:0] v);
        logic [1:0] r;
        axi_wr(`ARB_PARK_CONTROL_OFFSET, v, r);
        cmp_small("write_resp", 4'h0, {2'b00, r});
    endtask

    task automatic tally(input int k);
        gcnt = '{default: 0};
        repeat (k)
        begin
            @(posedge mclk);
            for (int j = 0; j < 4; j++)
                if (grant[j] === 1'b1)
                    gcnt[j]++;
        end
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        logic [31:0] d;
        logic [1:0]  r;
        {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {avail, bw, awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        want = 4'h0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        axi_rd(`ARB_PARK_CONTROL_OFFSET, d, r);
        cmp_word("ctrl_reset", `ARB_PARK_CONTROL_RESET, d);
        cmp_small("wide_reset", 4'h0, {3'h0, wide});
        // Reserved bits set on purpose to prove they are not stored
        set_ctrl(32'hFFFFFFFF);
        axi_rd(`ARB_PARK_CONTROL_OFFSET, d, r);
        cmp_word("ctrl_mask", `ARB_PARK_CONTROL_WMASK, d);
        cmp_small("wide_set", 4'h1, {3'h0, wide});
        axi_wr(8'h08, 32'h0, r);
        cmp_small("unmapped_wr", 4'h3, {2'b00, r});
        axi_rd(8'h04, d, r);
        cmp_word("unmapped_rd", 32'h0, d);
        cmp_small("unmapped_resp", 4'h3, {2'b00, r});
        for (int i = 0; i < 5; i++)
        begin
            set_ctrl(tc[i]);
            want <= tw[i];
            bw <= tb[i];
            repeat (5) @(posedge mclk);
            cmp_small("pointer", te[i], {2'b00, ptr});
        end
        bw <= 1'b0;
        want <= 4'h4;
        avail <= 1'b1;
        @(posedge mclk);
        #1 cmp_small("wait_grant", 4'h0, grant);
        @(posedge mclk);
        #1 cmp_small("zero_lat_grant", 4'h4, grant);
        @(posedge mclk);
        #1 cmp_small("owner", 4'h2, {2'b00, owner});
        @(posedge mclk);
        want <= 4'hC;
        repeat (6) @(posedge mclk);
        cmp_small("owner_holds", 4'h2, {2'b00, ptr});
        want <= 4'h0;
        repeat (4) @(posedge mclk);
        cmp_small("park_last", 4'h2, {2'b00, ptr});
        set_ctrl(32'h00E15000);
        repeat (3) @(posedge mclk);
        cmp_small("park_top", 4'h3, {2'b00, ptr});
        set_ctrl(32'h00E14000);
        want <= 4'h9;
        tally(20);
        cmp_small("m0_starved", 4'h0, {3'h0, gcnt[0] != 0});
        set_ctrl(32'h00E16100);
        tally(20);
        cmp_small("m0_lockout", 4'h1, {3'h0, gcnt[0] != 0});
        set_ctrl(32'h00E12F00);
        want <= 4'hF;
        tally(24);
        for (int i = 0; i < 4; i++)
            cmp_small("rr_turn", 4'h1, {3'h0, gcnt[i] != 0});
        test_done();
    end
endmodule // four_master_bus_arbiter_bench
